/* wwd_map.svh */
// register offsets, option byte fields and fixed values of the watchdog
`ifndef WWD_MAP_SVH
`define WWD_MAP_SVH

// apb byte offsets
`define WWD_OFF_SVC      8'h00
`define WWD_OFF_BITOP    8'h04
`define WWD_OFF_STAT     8'h08
`define WWD_OFF_OPT      8'h0c

// option byte field positions
`define WWD_OPT_WIN_HI   6
`define WWD_OPT_WIN_LO   5
`define WWD_OPT_EN       4
`define WWD_OPT_OVF_HI   3
`define WWD_OPT_OVF_LO   1
`define WWD_OPT_LOCK     0

// service key and read-back patterns
`define WWD_KEY          8'hac
`define WWD_RD_ON        8'h9a
`define WWD_RD_OFF       8'h1a

// shortest overflow period is 2**10 slow-clock ticks
`define WWD_BASE_LOG2    10

// data accesses that are never checked
`define WWD_EXA_LO       16'hfb00
`define WWD_EXA_HI       16'hffcf
`define WWD_EXB_LO       16'hffe0
`define WWD_EXB_HI       16'hffff

// reset values
`define WWD_OPT_RST      8'h00
`define WWD_DATA_RST     32'h0000_0000

`endif

/* wwd_pkg.sv */
// types shared by the watchdog modules
package wwd_pkg;

    typedef logic [16:0] wwd_count_t;

    // counter module state
    typedef struct packed {
        wwd_count_t count;
        logic       overflow;
        logic       window_open;
    } wwd_cnt_s;

    // control and bus state of the top module
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        rst_req;
        logic [7:0]  opt;
        logic        opt_ld;
        logic        first_done;
        logic        pend;
    } wwd_state_s;

endpackage

/* wwd_cnt_if.sv */
// link between the watchdog control logic and its counter
`timescale 1ns/1ns
interface wwd_cnt_if;
    logic               clear;
    logic               run;
    logic [2:0]         ovf_sel;
    logic [1:0]         win_sel;
    logic               overflow;
    logic               window_open;
    wwd_pkg::wwd_count_t count;

    modport counter (
        input  clear,
        input  run,
        input  ovf_sel,
        input  win_sel,
        output overflow,
        output window_open,
        output count
    );

    modport ctrl (
        output clear,
        output run,
        output ovf_sel,
        output win_sel,
        input  overflow,
        input  window_open,
        input  count
    );
endinterface

/* wwd_counter.sv */
// watchdog up-counter with overflow and window decode
`timescale 1ns/1ns
`include "wwd_map.svh"
module wwd_counter #(
    parameter int BASE_LOG2 = `WWD_BASE_LOG2
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    wwd_cnt_if.counter cnt
);

    wwd_pkg::wwd_cnt_s st;
    wwd_pkg::wwd_cnt_s next_st;

    // the largest period must fit the count type
    if (BASE_LOG2 < 2 || BASE_LOG2 + 7 > $bits(wwd_pkg::wwd_count_t)) begin
        $error("wwd_counter: BASE_LOG2 out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // next count, overflow pulse and window state
    always_comb begin
        wwd_pkg::wwd_count_t quarter;
        wwd_pkg::wwd_count_t last;
        wwd_pkg::wwd_count_t closed;
        closed  = '0;
        quarter = wwd_pkg::wwd_count_t'(1) << (BASE_LOG2 - 2 + cnt.ovf_sel);
        // with BASE_LOG2 at 10 the longest period wraps to all ones, the max count
        last    = (quarter << 2) - wwd_pkg::wwd_count_t'(1);
        unique case (cnt.win_sel)
            2'b00: closed = (quarter << 1) + quarter;
            2'b01: closed = quarter << 1;
            2'b10: closed = quarter;
            2'b11: closed = '0; // no closed window at full open
        endcase
        next_st          = st;
        next_st.overflow = 1'b0;
        // clear beats the roll-over, even on the very last count
        if (cnt.clear) begin
            // restart lands on the clearing edge, so only tick phase skews
            next_st.count = '0;
        end else if (cnt.run) begin
            if (st.count == last) begin
                next_st.count    = '0;
                next_st.overflow = 1'b1;
            end else begin
                next_st.count = st.count + wwd_pkg::wwd_count_t'(1);
            end
        end
        next_st.window_open = (next_st.count >= closed);
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cnt.count       = st.count;
    assign cnt.overflow    = st.overflow;
    assign cnt.window_open = st.window_open;

endmodule

/* wwd_top.sv */
// windowed watchdog: apb service port, option byte, access checks, reset
`timescale 1ns/1ns
`include "wwd_map.svh"
module wwd_top #(
    parameter int BASE_LOG2 = `WWD_BASE_LOG2,
    parameter int ADDR_W    = 8
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  option_byte,
    input  wire logic        slow_tick,
    input  wire logic        halt_mode,
    input  wire logic        stop_mode,
    input  wire logic        slow_osc_stop_bit,
    input  wire logic        fetch_valid,
    input  wire logic [15:0] fetch_addr,
    input  wire logic        fetch_area_ok,
    input  wire logic        data_valid,
    input  wire logic [15:0] data_addr,
    input  wire logic        data_area_ok,
    output logic             wdt_reset_req,
    output logic             watchdog_reset_flag_set
);

    wwd_pkg::wwd_state_s st;
    wwd_pkg::wwd_state_s next_st;
    wwd_cnt_if           cnt ();

    // offsets are compared on eight bits
    if (ADDR_W < 8) begin
        $error("wwd_top: ADDR_W must be at least 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded option byte and operating conditions
    logic       count_enable_option;
    logic       slow_osc_lock_option;
    logic [2:0] ovf_code;
    logic [1:0] open_code;
    logic       frozen;
    logic       acc;
    logic       done;
    logic [7:0] off;
    logic       wr_svc;
    logic       wr_bitop;
    logic       key_ok;
    logic       svc_clear;
    logic       err_key;
    logic       err_win;
    logic       err_fetch;
    logic       err_data;
    logic       data_exempt;
    logic       err_any;
    logic [7:0] svc_read;

    // the enable field counts only once latched after reset release
    assign count_enable_option  = st.opt_ld & st.opt[`WWD_OPT_EN];
    assign slow_osc_lock_option = st.opt[`WWD_OPT_LOCK];
    assign ovf_code  = st.opt[`WWD_OPT_OVF_HI:`WWD_OPT_OVF_LO];
    assign open_code = st.opt[`WWD_OPT_WIN_HI:`WWD_OPT_WIN_LO];

    // without the lock, halt, stop and the osc stop bit freeze the count
    assign frozen = ~slow_osc_lock_option
        & (halt_mode | stop_mode | slow_osc_stop_bit);

    // apb phases: one wait state, effect on the edge that sees pready
    assign acc  = psel & penable & ~st.pready;
    assign done = psel & penable & st.pready;
    assign off  = paddr[7:0];

    assign wr_svc   = done & pwrite & (off == `WWD_OFF_SVC);
    assign wr_bitop = done & pwrite & (off == `WWD_OFF_BITOP);
    assign key_ok   = (pwdata[7:0] == `WWD_KEY);

    // first key write always clears, later ones only in the open window
    assign svc_clear = wr_svc & key_ok
        & (~st.first_done | cnt.window_open);
    assign err_key = wr_svc & ~key_ok;
    assign err_win = wr_svc & key_ok & st.first_done
        & ~cnt.window_open;

    // memory checks are armed only by the enable option
    assign data_exempt =
        (data_addr >= `WWD_EXA_LO && data_addr <= `WWD_EXA_HI) ||
        (data_addr >= `WWD_EXB_LO && data_addr <= `WWD_EXB_HI);
    assign err_fetch = count_enable_option & fetch_valid
        & ~fetch_area_ok;
    assign err_data  = count_enable_option & data_valid & ~data_area_ok
        & ~data_exempt;

    assign err_any = err_key | err_win | wr_bitop | err_fetch | err_data
        | cnt.overflow;

    assign svc_read = count_enable_option ? `WWD_RD_ON
                                          : `WWD_RD_OFF;

    ////////////////////////////////////////////////////////////////////////
    // counter hookup: ticks only from the slow clock, not the cpu clock
    assign cnt.run = count_enable_option & slow_tick & ~frozen;
    assign cnt.clear   = svc_clear | st.rst_req;
    assign cnt.ovf_sel = ovf_code;
    assign cnt.win_sel = open_code;

    wwd_counter #(
        .BASE_LOG2 (BASE_LOG2)
    ) u_counter (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .cnt     (cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state: bus answer, option latch, reset request
    always_comb begin
        next_st         = st;
        next_st.rst_req = 1'b0;
        // option byte is a level captured once after reset release
        if (!st.opt_ld) begin
            next_st.opt    = option_byte;
            next_st.opt_ld = 1'b1;
        end
        // answer on the cycle after the first access cycle
        next_st.pready  = acc;
        next_st.pslverr = 1'b0;
        next_st.prdata  = `WWD_DATA_RST;
        if (acc) begin
            unique case (off)
                `WWD_OFF_SVC:   next_st.prdata = {24'h0, svc_read};
                `WWD_OFF_BITOP: next_st.prdata = `WWD_DATA_RST;
                `WWD_OFF_STAT:  next_st.prdata = {12'h0, cnt.window_open,
                    st.first_done, st.pend, cnt.count};
                `WWD_OFF_OPT:   next_st.prdata = {24'h0, st.opt};
                default:        next_st.pslverr = 1'b1;
            endcase
        end
        if (svc_clear) begin
            next_st.first_done = 1'b1;
        end
        // with the count frozen the reset waits until the freeze ends
        if (err_any | st.pend) begin
            if (frozen) begin
                next_st.pend = 1'b1;
            end else begin
                next_st.rst_req    = 1'b1;
                next_st.pend       = 1'b0;
                next_st.first_done = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st        <= '0;
            st.opt    <= `WWD_OPT_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata                  = st.prdata;
    assign pready                  = st.pready;
    assign pslverr                 = st.pslverr;
    assign wdt_reset_req           = st.rst_req;
    assign watchdog_reset_flag_set = st.rst_req;

    ////////////////////////////////////////////////////////////////////////
    // checks on the design's own behaviour
    AST_OVF_RESET: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        cnt.overflow |=> wdt_reset_req && watchdog_reset_flag_set)
        else $error("overflow did not raise reset");

    AST_BAD_KEY: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_svc && pwdata[7:0] != `WWD_KEY && !frozen |=> wdt_reset_req)
        else $error("wrong key did not raise reset");

    AST_BITOP: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_bitop && !frozen |=> wdt_reset_req)
        else $error("bit write did not raise reset");

    AST_CLOSED_WIN: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_svc && key_ok && st.first_done && !cnt.window_open && !frozen
        |=> wdt_reset_req)
        else $error("closed window write did not raise reset");

    AST_FIRST_CLEAR: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_svc && key_ok && !st.first_done && !err_any && !st.pend
        |=> cnt.count == '0 && !wdt_reset_req && st.first_done)
        else $error("first key write did not clear");

    AST_READ_PATTERN: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        pready && !pwrite && off == `WWD_OFF_SVC
        |-> prdata[7:0] == (st.opt[`WWD_OPT_EN] ? 8'h9a : 8'h1a))
        else $error("service read pattern wrong");

    AST_FREEZE: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        frozen && !cnt.clear ##1 frozen |-> cnt.count == $past(cnt.count))
        else $error("count moved while frozen");

    AST_PULSE: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wdt_reset_req |=> !wdt_reset_req && cnt.count == '0)
        else $error("reset request not a clearing pulse");

    AST_DATA_CHECK: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        count_enable_option && data_valid && !data_area_ok
        && !data_exempt && !frozen |=> wdt_reset_req)
        else $error("illegal data access missed");

    AST_DISABLED: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !count_enable_option && !cnt.clear |=> $stable(cnt.count))
        else $error("counter ran while disabled");

    ////////////////////////////////////////////////////////////////////////
    // fetch, window, counter and pending-reset checks
    AST_FETCH_CHECK: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        count_enable_option && fetch_valid && !fetch_area_ok && !frozen
        |=> wdt_reset_req)
        else $error("illegal fetch missed");

    AST_OPEN_CLEAR: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_svc && key_ok && st.first_done && cnt.window_open
        && !err_any && !st.pend
        |=> cnt.count == '0 && !wdt_reset_req)
        else $error("open window key write did not clear");

    AST_WIN_CLOSED: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        st.opt_ld && open_code != 2'b11 && cnt.clear
        |=> !cnt.window_open)
        else $error("window open right after clear");

    AST_FULL_OPEN: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        st.opt_ld && open_code == 2'b11
        |=> cnt.window_open)
        else $error("window closed at full open setting");

    AST_CLEAR_WINS: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        cnt.clear
        |=> cnt.count == '0 && !cnt.overflow)
        else $error("clear lost against roll-over");

    AST_NO_TICK: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !slow_tick && !cnt.clear
        |=> $stable(cnt.count))
        else $error("count moved without a slow tick");

    AST_PEND_HOLD: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        frozen && err_any
        |=> st.pend && !wdt_reset_req)
        else $error("reset not held while frozen");

    AST_PEND_FIRE: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        st.pend && !frozen
        |=> wdt_reset_req)
        else $error("held reset not raised on resume");

    AST_REQ_FIRST: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wdt_reset_req
        |-> !st.first_done)
        else $error("reset left first write marker set");

endmodule

/* wwd_cpu_model.sv */
// cpu side model: apb master plus fetch and data access strobes
`timescale 1ns/1ns
module wwd_cpu_model (
    input  wire logic        clk_sys,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             fetch_valid,
    output logic             data_valid,
    output logic [15:0]      acc_addr,
    output logic             area_ok
);
    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fetch_valid = 1'b0;
        data_valid = 1'b0;
        acc_addr = 16'h0;
        area_ok = 1'b1;
    end
    ////////////////////////////////////////////////////////////
    // one transfer, held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // no limit of its own: the bench watchdog ends a hang
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // scrambled so a stale value is never mistaken for live data
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    // one access strobe of one cycle
    task automatic mem(input logic fetch, input logic [15:0] a,
                       input logic ok);
        @(posedge clk_sys);
        fetch_valid <= fetch;
        data_valid <= ~fetch;
        acc_addr <= a;
        area_ok <= ok;
        @(posedge clk_sys);
        fetch_valid <= 1'b0;
        data_valid <= 1'b0;
        acc_addr <= ~a;
        area_ok <= ~ok;
    endtask
endmodule

/* testbench.sv */
// self-checking bench for the windowed watchdog top
`timescale 1ns/1ns
`include "wwd_map.svh"
module testbench;
    localparam int B = 2;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  option_byte = 8'h00;
    logic        slow_tick = 1'b0;
    logic        halt_mode = 1'b0;
    logic        stop_mode = 1'b0;
    logic        slow_osc_stop_bit = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        fetch_valid, data_valid, area_ok, req_d = 1'b0;
    logic [15:0] acc_addr;
    logic        wdt_reset_req, watchdog_reset_flag_set;
    int          error_cnt = 0, checks_done = 0, rst_cnt = 0, div = 0;

    wwd_top #(.BASE_LOG2(B), .ADDR_W(8)) dut (
        .clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .option_byte, .slow_tick, .halt_mode,
        .stop_mode, .slow_osc_stop_bit, .fetch_valid,
        .fetch_addr(acc_addr), .fetch_area_ok(area_ok), .data_valid,
        .data_addr(acc_addr), .data_area_ok(area_ok), .wdt_reset_req,
        .watchdog_reset_flag_set);
    wwd_cpu_model cpu (
        .clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .fetch_valid, .data_valid, .acc_addr, .area_ok);

    always #50 clk_sys = ~clk_sys;
    // slow clock stand-in: one tick every four system cycles
    always @(posedge clk_sys) begin
        div <= (div + 1) % 4;
        slow_tick <= (div == 3);
    end
    // count reset pulses; each must be single and flagged
    always @(posedge clk_sys) begin
        req_d <= wdt_reset_req;
        if (wdt_reset_req === 1'b1) begin
            rst_cnt++;
            chk(watchdog_reset_flag_set, 1, "flag");
            chk(req_d, 0, "pulse width");
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    function automatic logic [7:0] ob(input logic [1:0] w, input logic e,
                                      input logic [2:0] s, input logic l);
        return {1'b0, w, e, s, l};
    endfunction
    // option byte only latches on reset, so every case reboots
    task automatic boot(input logic [7:0] opt);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        option_byte <= opt;
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst_cnt = 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu.xfer(1'b1, a, {24'h0, d}, rd, err);
    endtask
    task automatic rdr(input logic [7:0] a);
        cpu.xfer(1'b0, a, 32'h0, rd, err);
    endtask
    task automatic wait_rst(input int lim, output int n);
        n = 0;
        while (wdt_reset_req !== 1'b1 && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_read();
        for (int e = 0; e < 2; e++) begin
            boot(ob(2'h3, e[0], 3'h2, 1'b1));
            rdr(`WWD_OFF_SVC);
            chk(rd[7:0], e ? `WWD_RD_ON : `WWD_RD_OFF, "svc");
            rdr(8'h10);
            chk(err, 1, "unmapped");
        end
        $display("test read done");
    endtask
    task automatic t_ovf();
        int n, t;
        for (int s = 0; s < 8; s++) begin
            boot(ob(2'h3, 1'b1, s[2:0], 1'b1));
            t = 4 << (B + s);
            wait_rst(t + 64, n);
            chk(n >= t - 8 && n <= t + 8, 1, "period");
        end
        boot(ob(2'h3, 1'b0, 3'h0, 1'b1));
        cpu.mem(1'b1, 16'h1000, 1'b0);
        repeat (64) @(posedge clk_sys);
        chk(rst_cnt, 0, "disabled");
        $display("test overflow done");
    endtask
    task automatic t_win();
        int n, t;
        boot(ob(2'h0, 1'b1, 3'h3, 1'b1));
        repeat (64) @(posedge clk_sys);
        wr(`WWD_OFF_SVC, `WWD_KEY);
        rdr(`WWD_OFF_STAT);
        chk(rd[16:0] < 17'h2, 1, "first");
        chk(rst_cnt, 0, "first kept");
        for (int w = 0; w < 3; w++) begin
            boot(ob(w[1:0], 1'b1, 3'h3, 1'b1));
            wr(`WWD_OFF_SVC, `WWD_KEY);
            repeat (32 * (3 - w) - 12) @(posedge clk_sys);
            rdr(`WWD_OFF_STAT);
            chk(rd[19], 0, "closed");
            repeat (16) @(posedge clk_sys);
            rdr(`WWD_OFF_STAT);
            chk(rd[19], 1, "open");
            wr(`WWD_OFF_SVC, `WWD_KEY);
            rdr(`WWD_OFF_STAT);
            chk(rd[16:0] < 17'h2, 1, "cleared");
            wr(`WWD_OFF_SVC, `WWD_KEY);
            repeat (3) @(posedge clk_sys);
            chk(rst_cnt, 1, "closed write");
        end
        boot(ob(2'h3, 1'b1, 3'h3, 1'b1));
        wr(`WWD_OFF_SVC, `WWD_KEY);
        wr(`WWD_OFF_SVC, `WWD_KEY);
        repeat (3) @(posedge clk_sys);
        chk(rst_cnt, 0, "always open");
        // period after a key clear, two slow ticks of slack
        t = 4 << (B + 3);
        wait_rst(t + 64, n);
        chk(n >= t - 8 && n <= t + 8, 1, "reclear");
        $display("test window done");
    endtask
    task automatic t_bad();
        for (int k = 0; k < 2; k++) begin
            boot(ob(2'h3, 1'b1, 3'h7, 1'b1));
            wr(k ? `WWD_OFF_BITOP : `WWD_OFF_SVC, k ? `WWD_KEY : 8'h55);
            repeat (3) @(posedge clk_sys);
            chk(rst_cnt, 1, "bad write");
            rdr(`WWD_OFF_SVC);
            chk(rd[7:0], `WWD_RD_ON, "after reset");
        end
        $display("test bad write done");
    endtask
    task automatic t_acc();
        logic [15:0] ex [4] = '{16'hfb00, 16'hffcf, 16'hffe0, 16'hffff};
        boot(ob(2'h3, 1'b1, 3'h7, 1'b1));
        cpu.mem(1'b1, 16'h1000, 1'b1);
        foreach (ex[i]) cpu.mem(1'b0, ex[i], 1'b0);
        repeat (3) @(posedge clk_sys);
        chk(rst_cnt, 0, "exempt");
        cpu.mem(1'b0, 16'hffd0, 1'b0);
        repeat (3) @(posedge clk_sys);
        chk(rst_cnt, 1, "data area");
        boot(ob(2'h3, 1'b1, 3'h7, 1'b1));
        cpu.mem(1'b1, 16'h1000, 1'b0);
        repeat (3) @(posedge clk_sys);
        chk(rst_cnt, 1, "fetch area");
        $display("test access done");
    endtask
    // freeze mid-count; a cleared count would need 29 cycles or more
    task automatic t_frz();
        int n;
        for (int k = 0; k < 4; k++) begin
            boot(ob(2'h3, 1'b1, 3'h1, k == 3));
            repeat (20) @(posedge clk_sys);
            halt_mode <= (k == 0 || k == 3);
            stop_mode <= (k == 1);
            slow_osc_stop_bit <= (k == 2);
            repeat (100) @(posedge clk_sys);
            chk(rst_cnt > 0, k == 3, "frozen");
            halt_mode <= 1'b0;
            stop_mode <= 1'b0;
            slow_osc_stop_bit <= 1'b0;
            wait_rst(40, n);
            chk(n <= 24, 1, "resume");
        end
        // a bad key while frozen waits and fires on resume
        boot(ob(2'h3, 1'b1, 3'h7, 1'b0));
        halt_mode <= 1'b1;
        wr(`WWD_OFF_SVC, 8'h55);
        repeat (8) @(posedge clk_sys);
        chk(rst_cnt, 0, "held");
        halt_mode <= 1'b0;
        wait_rst(8, n);
        chk(n <= 2, 1, "fired on resume");
        $display("test freeze done");
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        t_read();
        t_ovf();
        t_win();
        t_bad();
        t_acc();
        t_frz();
        test_done();
    end
    // tests need about 6000 cycles; allow over three times that
    initial begin
        #(100 * 20000);
        error_cnt++;
        test_done();
    end
endmodule
